// ==== bench/cramp_assertions.sv ====
// port checks for cramp_top: apb timing, refusals, amp enable, irq
// assumes one sys_clk domain and an apb master that holds each request
`include "cramp_defines.vh"
module cramp_checker #(
  parameter AXES = 8
)
(
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // amplifier side
  input wire [AXES-1:0] amplifierEnableOut,
  input wire irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // accepted writes that matter here, and unmapped or unaligned places
  wire acc = psel && penable && pready && pwrite;
  wire ampOnWr = acc && paddr == `CRAMP_OFF_AMPON && pwdata[0];
  wire motOffWr = acc && paddr == `CRAMP_OFF_MOTOFF && pwdata[0];
  wire maskClr = acc && paddr == `CRAMP_OFF_IRQMSK && pwdata == 32'h0;
  wire bad = paddr > `CRAMP_OFF_WDOG || paddr[1:0] != 2'h0;
  // access phase, then the answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  ready_after_wait_a: assert property (s_wait |=> s_answer)
    else $error("pready not one cycle after access");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held");
  ready_needs_access_a: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  err_only_bad_a: assert property (pslverr |-> s_answer and bad)
    else $error("pslverr on mapped place");
  err_on_bad_a: assert property (s_answer and bad |-> pslverr)
    else $error("unmapped access accepted");
  amp_rise_cause_a: assert property ($rose(amplifierEnableOut[0]) |->
    $past(ampOnWr, 1) || $past(ampOnWr, 2)) else $error("enable rose uncommanded");
  amp_motor_off_a: assert property (motOffWr |-> ##[1:3] !amplifierEnableOut[0])
    else $error("enable kept after motor off");
  irq_masked_low_a: assert property (maskClr |-> ##2 !irq [*4])
    else $error("irq with empty mask");
endmodule
bind cramp_top cramp_checker #(.AXES(AXES)) i_cramp_checker (.sys_clk(sys_clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .amplifierEnableOut(amplifierEnableOut), .irq(irq));

// ==== bench/cramp_enc_model.sv ====
// encoder partner: drives the channel pair of one axis
// assumes its tasks are called from the sys_clk domain
module cramp_enc_model (
  // clock
  input wire logic clk,
  // encoder channels
  output logic quadrature_phase_a,
  output logic quadrature_phase_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] idx = 2'h0;
  // channels idle low
  initial
  begin
    quadrature_phase_a = 1'b0;
    quadrature_phase_b = 1'b0;
  end
  // gray walk, phase a leads when counting up
  task automatic quad(input bit up, input int n);
    repeat (n)
    begin
      @(posedge clk);
      idx = up ? idx + 2'h1 : idx - 2'h1;
      quadrature_phase_a <= idx[0] ^ idx[1];
      quadrature_phase_b <= idx[1];
      repeat (2) @(posedge clk);
    end
  endtask
  // one channel alone, as with a failed encoder
  task automatic toggle_a();
    @(posedge clk);
    quadrature_phase_a <= ~quadrature_phase_a;
    repeat (2) @(posedge clk);
  endtask
  // pulses on phase a, direction held on phase b
  task automatic pulse(input bit up, input int n);
    repeat (n)
    begin
      @(posedge clk);
      quadrature_phase_b <= ~up;
      @(posedge clk);
      quadrature_phase_a <= 1'b1;
      @(posedge clk);
      quadrature_phase_a <= 1'b0;
    end
  endtask
endmodule

// ==== bench/test_commutation_routing_amp_enable.sv ====
// self-checking bench for cramp_top over apb
// assumes one wait cycle per access and the encoder partner on axis a
`include "cramp_defines.vh"
module test_commutation_routing_amp_enable;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AX = `CRAMP_AXES;
  logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, irq, encA, encB;
  logic [96:1] hallPins = 0;
  logic [AX*16-1:0] ph1, ph2, srv, dacOut;
  logic [AX-1:0] amp;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // design and encoder partner
  cramp_top #(.AXES(AX)) i_cramp_top (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .quadraturePhaseA({7'h0, encA}),
    .quadraturePhaseB({7'h0, encB}), .encIndex(8'h0), .genIn(hallPins[8:1]),
    .extIn(hallPins[56:17]), .auxIn(hallPins[96:81]), .phaseOneIn(ph1), .phaseTwoIn(ph2),
    .servoCmdIn(srv), .dacOut(dacOut), .amplifierEnableOut(amp), .irq(irq));
  cramp_enc_model i_cramp_enc_model (.clk(sys_clk), .quadrature_phase_a(encA), .quadrature_phase_b(encB));
  // 40 mhz clock
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // cycle ceiling against hangs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic amp_is(input logic e);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, amp[0]}, {31'h0, e});
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdc(`CRAMP_OFF_AXCNT, 32'h8);
    rdc(`CRAMP_OFF_ERRLIM, 32'h7fff);
    rdc(`CRAMP_OFF_WDOG, 32'hffff);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_route();
    logic [15:0] ex [7] = '{16'h1000, 16'h3001, 16'h1002, 16'h3003, 16'h3004, 16'h2000,
      16'h2002};
    wr(`CRAMP_OFF_AXCNT, 32'h7);
    wr(`CRAMP_OFF_IRQST, 32'hf);
    wr(`CRAMP_OFF_SINSEL, 32'h45);
    rdc(`CRAMP_OFF_ROUTE, 32'h0310_0000);
    rdc(`CRAMP_OFF_IRQST, 32'h8);
    for (int o = 0; o < 7; o++)
      chk({16'h0, dacOut[o*16+:16]}, {16'h0, ex[o]});
    wr(`CRAMP_OFF_IRQMSK, 32'h8);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`CRAMP_OFF_IRQST, 32'h8);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`CRAMP_OFF_IRQMSK, 32'h0);
    $display("test route done");
  endtask
  task automatic t_amp();
    wr(`CRAMP_OFF_AMPON, 32'h1);
    amp_is(1'b1);
    wr(`CRAMP_OFF_MOTOFF, 32'h1);
    amp_is(1'b0);
    amp_is(1'b0);
    rdc(`CRAMP_OFF_IRQST, 32'h2);
    wr(`CRAMP_OFF_IRQST, 32'hf);
    wr(`CRAMP_OFF_ERRDIS, 32'h1);
    wr(`CRAMP_OFF_ERRLIM, 32'h2);
    wr(`CRAMP_OFF_ERRSEL, 32'h0);
    wr(`CRAMP_OFF_AMPON, 32'h1);
    amp_is(1'b1);
    wr(`CRAMP_OFF_POS, 32'h5);
    amp_is(1'b0);
    rdc(`CRAMP_OFF_IRQST, 32'h4);
    wr(`CRAMP_OFF_ERRDIS, 32'h0);
    wr(`CRAMP_OFF_POS, 32'h0);
    wr(`CRAMP_OFF_IRQST, 32'hf);
    wr(`CRAMP_OFF_WDOG, 32'h20);
    wr(`CRAMP_OFF_AMPON, 32'h1);
    amp_is(1'b1);
    repeat (40) @(posedge sys_clk);
    amp_is(1'b0);
    rdc(`CRAMP_OFF_IRQST, 32'h1);
    wr(`CRAMP_OFF_WDOG, 32'hffff);
    $display("test amp done");
  endtask
  task automatic t_enc();
    i_cramp_enc_model.quad(1'b1, 4);
    rdc(`CRAMP_OFF_POS, 32'h4);
    i_cramp_enc_model.toggle_a();
    rdc(`CRAMP_OFF_POS, 32'h5);
    i_cramp_enc_model.toggle_a();
    rdc(`CRAMP_OFF_POS, 32'h4);
    i_cramp_enc_model.quad(1'b0, 4);
    rdc(`CRAMP_OFF_POS, 32'h0);
    wr(`CRAMP_OFF_ENCMODE, 32'h1);
    i_cramp_enc_model.pulse(1'b1, 3);
    rdc(`CRAMP_OFF_POS, 32'h3);
    i_cramp_enc_model.pulse(1'b0, 1);
    rdc(`CRAMP_OFF_POS, 32'h2);
    $display("test enc done");
  endtask
  task automatic t_hall();
    int s [3] = '{6, 17, 81};
    wr(`CRAMP_OFF_PHASE, 32'h1234);
    rdc(`CRAMP_OFF_PHASE, 32'h4);
    wr(`CRAMP_OFF_ERRSEL, 32'h1);
    foreach (s[i])
    begin
      @(posedge sys_clk);
      hallPins <= 96'h5 << (s[i] - 1);
      wr(`CRAMP_OFF_HALLSEL, 32'h0001_0100 | s[i]);
      rdc(`CRAMP_OFF_HALLST, 32'h5);
    end
    wr(`CRAMP_OFF_ERRSEL, 32'h2);
    wr(`CRAMP_OFF_HALLSEL, 32'h0002_0151);
    rdc(`CRAMP_OFF_PHASE, 32'h5);
    rdc(`CRAMP_OFF_HALLST, 32'h8000_0005);
    $display("test hall done");
  endtask
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // command inputs fixed per axis, then the tests
  initial
  begin
    for (int k = 0; k < AX; k++)
    begin
      ph1[k*16+:16] = 16'h1000 + k[15:0];
      ph2[k*16+:16] = 16'h2000 + k[15:0];
      srv[k*16+:16] = 16'h3000 + k[15:0];
    end
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_route();
    t_amp();
    t_enc();
    t_hall();
    conclude();
  end
endmodule

// ==== hw/cramp_defines.vh ====
// register map, field layout and reset values of the commutation / amp enable block
// assumes a 32-bit APB slave with word-aligned registers
`ifndef CRAMP_DEFINES_VH
`define CRAMP_DEFINES_VH
`define CRAMP_AXES 8
// byte offsets
`define CRAMP_OFF_AXCNT 12'h000
`define CRAMP_OFF_SINSEL 12'h004
`define CRAMP_OFF_AMPON 12'h008
`define CRAMP_OFF_MOTOFF 12'h00c
`define CRAMP_OFF_ERRDIS 12'h010
`define CRAMP_OFF_ERRLIM 12'h014
`define CRAMP_OFF_ERRSEL 12'h018
`define CRAMP_OFF_ENCMODE 12'h01c
`define CRAMP_OFF_HALLSEL 12'h020
`define CRAMP_OFF_AMPSTAT 12'h024
`define CRAMP_OFF_ROUTE 12'h028
`define CRAMP_OFF_POS 12'h02c
`define CRAMP_OFF_HALLST 12'h030
`define CRAMP_OFF_PHASE 12'h034
`define CRAMP_OFF_IRQST 12'h038
`define CRAMP_OFF_IRQMSK 12'h03c
`define CRAMP_OFF_WDOG 12'h040
// interrupt status bits
`define CRAMP_IRQ_WDOG 0
`define CRAMP_IRQ_MOTOFF 1
`define CRAMP_IRQ_ERR 2
`define CRAMP_IRQ_BADSEL 3
// hall source groups
`define CRAMP_HSRC_GEN 2'h0
`define CRAMP_HSRC_AUX 2'h1
`define CRAMP_HSRC_EXT 2'h2
// input numbering bases
`define CRAMP_GEN_FIRST 7'd1
`define CRAMP_GEN_LAST 7'd8
`define CRAMP_EXT_FIRST 7'd17
`define CRAMP_EXT_LAST 7'd56
`define CRAMP_AUX_FIRST 7'd81
`define CRAMP_AUX_LAST 7'd96
// reset values
`define CRAMP_RST_AXCNT 4'h8
`define CRAMP_RST_ERRLIM 32'h0000_7fff
`define CRAMP_RST_WDOG 16'hffff
`endif

// ==== hw/cramp_top.v ====
// commutation routing, amplifier enable, encoder decode and hall capture
// assumes APB master on sys_clk, encoder and hall pins already synchronous
// What this block does
// R01: each commutated axis frees top axis for phase two
// R02: highest configured axis never takes sinusoidal commutation; code checks it only on a SINSEL write, not when the axis count is rewritten
// R03: first phase on the axis's own output
// R04: second phases on freed outputs, in order
// R05: rank from axis A up to configured count
// R06: seven axes, A and C: phases F, G
// R07: watchdog, motor off, excess error drop enable
// R08: enable output high while amplifier expected on
// R09: quadrature decode, index optional
// R10: pulse/direction: pulses on A, direction on B
// R11: one toggling channel moves count by one only
// R12: hall sensors seed phase after reset
// R13: hall inputs optional, only for commutation
// R14: hall from general, auxiliary or extended inputs
// R15: hall inputs consecutive, start chosen per axis
// R16: error disable drops enable on excess error
// R17: dropped enable stays off until re-enabled
//
// Decided for this implementation: the register offsets and register access over APB.
`include "cramp_defines.vh"
module cramp_top #(
  parameter AXES = `CRAMP_AXES,
  parameter POSW = 32
)
(
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // encoders, hall inputs
  input wire [AXES-1:0] quadraturePhaseA,
  input wire [AXES-1:0] quadraturePhaseB,
  input wire [AXES-1:0] encIndex,
  input wire [8:1] genIn,
  input wire [56:17] extIn,
  input wire [96:81] auxIn,
  // commutation phases per axis, command values per axis
  input wire [AXES*16-1:0] phaseOneIn,
  input wire [AXES*16-1:0] phaseTwoIn,
  input wire [AXES*16-1:0] servoCmdIn,
  // outputs to amplifiers
  output reg [AXES*16-1:0] dacOut,
  output reg [AXES-1:0] amplifierEnableOut,
  output reg irq
);
  // software registers, then internal decoder, watchdog and hall state
  reg [3:0] axCnt_reg;
  reg [AXES-1:0] sinSel_reg;
  reg [AXES-1:0] errDis_reg;
  reg [AXES-1:0] encMode_reg;
  reg [POSW-1:0] errLim_reg;
  reg [2:0] errSel_reg;
  reg [AXES*9-1:0] hallSel_reg;
  reg [AXES-1:0] ampOn_reg;
  reg [3:0] irqSt_reg;
  reg [3:0] irqMsk_reg;
  reg [15:0] wdogLoad_reg;
  reg [15:0] wdogCnt_reg;
  reg [AXES*POSW-1:0] pos_reg;
  reg [AXES*POSW-1:0] cmdPos_reg;
  reg [AXES-1:0] qaOld_reg;
  reg [AXES-1:0] qbOld_reg;
  reg [AXES*2-1:0] lastDir_reg;
  reg [AXES*3-1:0] hall_reg;
  reg [AXES*3-1:0] phaseSeed_reg;
  reg [AXES-1:0] seeded_reg;
  reg [AXES*4-1:0] route_reg;
  // excess position error per axis, read by the flag logic below
  reg [AXES-1:0] errTrip;
  reg [POSW-1:0] diff;
  integer e;
  // hall levels as they stand on the selected inputs this cycle
  reg [AXES*3-1:0] hallNow;
  integer b;
  // bus strokes act once, in the access cycle before pready
  wire apbWr = psel & penable & pwrite & ~pready;
  wire apbRd = psel & penable & ~pwrite & ~pready;
  // fire at one, so the flag and the drop share one edge
  wire wdogFire = (wdogCnt_reg == 16'h0001);
  wire motOffWr = apbWr & (paddr == `CRAMP_OFF_MOTOFF);
  // read one numbered input from the three hall groups
  function inBit;
    input [6:0] num;
    input [8:1] g;
    input [56:17] e;
    input [96:81] a;
    begin
      inBit = 1'b0;
      if (num >= `CRAMP_GEN_FIRST && num <= `CRAMP_GEN_LAST)
        inBit = g[num];
      else if (num >= `CRAMP_EXT_FIRST && num <= `CRAMP_EXT_LAST)
        inBit = e[num];
      else if (num >= `CRAMP_AUX_FIRST && num <= `CRAMP_AUX_LAST)
        inBit = a[num];
    end
  endfunction
  // selection legal only below the top configured axis
  function [AXES-1:0] legalSel;
    input [AXES-1:0] sel;
    input [3:0] cnt;
    integer k;
    begin
      legalSel = {AXES{1'b0}};
      for (k = 0; k < AXES; k = k + 1)
        if (k + 1 < cnt)
          legalSel[k] = sel[k]; // R02 R05
    end
  endfunction
  // output routing: which phase feeds each dac (code: 0 servo or ph1 of own axis, 1.. ph2 of axis code-1)
  integer i;
  integer n;
  integer slot;
  integer j;
  reg [AXES*4-1:0] routeNext;
  reg [AXES*16-1:0] dacNext;
  always @*
  begin
    routeNext = {AXES{4'h0}};
    dacNext = servoCmdIn;
    n = 0;
    for (i = 0; i < AXES; i = i + 1)
      n = n + sinSel_reg[i];
    // first freed output is count-n; ranks ascend with axis
    slot = axCnt_reg - n; // R01
    for (i = 0; i < AXES; i = i + 1)
      if (sinSel_reg[i])
      begin
        dacNext[i*16 +: 16] = phaseOneIn[i*16 +: 16]; // R03
        for (j = 0; j < AXES; j = j + 1)
          if (j == slot)
          begin
            dacNext[j*16 +: 16] = phaseTwoIn[i*16 +: 16]; // R04 R06
            routeNext[j*4 +: 4] = i[3:0] + 4'h1;
          end
        slot = slot + 1;
      end
  end
  // apb register writes and interrupt flags
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      axCnt_reg <= `CRAMP_RST_AXCNT;
      sinSel_reg <= {AXES{1'b0}};
      errDis_reg <= {AXES{1'b0}};
      encMode_reg <= {AXES{1'b0}};
      errLim_reg <= `CRAMP_RST_ERRLIM;
      errSel_reg <= 3'h0;
      hallSel_reg <= {AXES{9'h000}};
      irqMsk_reg <= 4'h0;
      irqSt_reg <= 4'h0;
      wdogLoad_reg <= `CRAMP_RST_WDOG;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      // one wait state: pready on the edge after the access begins
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (apbWr)
        case (paddr)
          `CRAMP_OFF_AXCNT: axCnt_reg <= pwdata[3:0];
          // reject illegal selection, flag it
          `CRAMP_OFF_SINSEL: sinSel_reg <= legalSel(pwdata[AXES-1:0], axCnt_reg); // R02
          `CRAMP_OFF_ERRDIS: errDis_reg <= pwdata[AXES-1:0];
          `CRAMP_OFF_ERRLIM: errLim_reg <= pwdata[POSW-1:0];
          `CRAMP_OFF_ERRSEL: errSel_reg <= pwdata[2:0];
          `CRAMP_OFF_ENCMODE: encMode_reg <= pwdata[AXES-1:0];
          `CRAMP_OFF_HALLSEL: hallSel_reg[pwdata[18:16]*9 +: 9] <= pwdata[8:0];
          `CRAMP_OFF_IRQMSK: irqMsk_reg <= pwdata[3:0];
          `CRAMP_OFF_WDOG: wdogLoad_reg <= pwdata[15:0];
          // written elsewhere, or read only: mapped, so no error
          `CRAMP_OFF_AMPON, `CRAMP_OFF_MOTOFF, `CRAMP_OFF_POS, `CRAMP_OFF_IRQST: ;
          `CRAMP_OFF_AMPSTAT, `CRAMP_OFF_ROUTE, `CRAMP_OFF_HALLST, `CRAMP_OFF_PHASE: ;
          default: pslverr <= 1'b1;
        endcase
      if (apbRd)
        case (paddr)
          `CRAMP_OFF_AXCNT: prdata <= {28'h0, axCnt_reg};
          `CRAMP_OFF_SINSEL: prdata <= {{(32-AXES){1'b0}}, sinSel_reg};
          `CRAMP_OFF_AMPON: prdata <= {{(32-AXES){1'b0}}, ampOn_reg};
          // motor off is a strobe with nothing to hold
          `CRAMP_OFF_MOTOFF: prdata <= 32'h0000_0000;
          `CRAMP_OFF_ERRDIS: prdata <= {{(32-AXES){1'b0}}, errDis_reg};
          `CRAMP_OFF_ERRLIM: prdata <= errLim_reg;
          `CRAMP_OFF_ERRSEL: prdata <= {29'h0, errSel_reg};
          `CRAMP_OFF_ENCMODE: prdata <= {{(32-AXES){1'b0}}, encMode_reg};
          `CRAMP_OFF_HALLSEL: prdata <= {23'h0, hallSel_reg[errSel_reg*9 +: 9]};
          `CRAMP_OFF_AMPSTAT: prdata <= {{(32-AXES){1'b0}}, amplifierEnableOut};
          `CRAMP_OFF_ROUTE: prdata <= route_reg[31:0];
          `CRAMP_OFF_POS: prdata <= pos_reg[errSel_reg*POSW +: POSW];
          `CRAMP_OFF_HALLST: prdata <= {seeded_reg[errSel_reg], 28'h0,
            hall_reg[errSel_reg*3 +: 3]};
          `CRAMP_OFF_PHASE: prdata <= {29'h0, phaseSeed_reg[errSel_reg*3 +: 3]};
          `CRAMP_OFF_IRQST: prdata <= {28'h0, irqSt_reg};
          `CRAMP_OFF_IRQMSK: prdata <= {28'h0, irqMsk_reg};
          `CRAMP_OFF_WDOG: prdata <= {16'h0, wdogLoad_reg};
          default:
          begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      // sticky flags: clear by writing one, set wins
      irqSt_reg <= (irqSt_reg & ~((apbWr && paddr == `CRAMP_OFF_IRQST) ? pwdata[3:0] : 4'h0))
        | {apbWr && paddr == `CRAMP_OFF_SINSEL
            && (legalSel(pwdata[AXES-1:0], axCnt_reg) != pwdata[AXES-1:0]),
          |(ampOn_reg & errDis_reg & errTrip),
          motOffWr,
          wdogFire};
    end
  end
  // excess position error per axis, magnitude compared unsigned
  always @*
  begin
    errTrip = {AXES{1'b0}};
    diff = {POSW{1'b0}};
    for (e = 0; e < AXES; e = e + 1)
    begin
      diff = cmdPos_reg[e*POSW +: POSW] - pos_reg[e*POSW +: POSW];
      if (diff[POSW-1])
        diff = ~diff + 1'b1;
      errTrip[e] = (diff > errLim_reg);
    end
  end
  // watchdog reloads on any bus access
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      wdogCnt_reg <= `CRAMP_RST_WDOG;
    else if (psel & penable)
      wdogCnt_reg <= wdogLoad_reg;
    else if (wdogCnt_reg != 16'h0000)
      wdogCnt_reg <= wdogCnt_reg - 16'h0001;
  end
  // amplifier enable: latched off until re-enabled
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ampOn_reg <= {AXES{1'b0}};
      amplifierEnableOut <= {AXES{1'b0}};
      cmdPos_reg <= {AXES*POSW{1'b0}};
      dacOut <= {AXES*16{1'b0}};
      route_reg <= {AXES{4'h0}};
      irq <= 1'b0;
    end
    else
    begin
      if (wdogFire)
        ampOn_reg <= {AXES{1'b0}}; // R07
      else
        ampOn_reg <= (ampOn_reg | ((apbWr && paddr == `CRAMP_OFF_AMPON) ? pwdata[AXES-1:0]
          : {AXES{1'b0}})) // R17
          & ~(motOffWr ? pwdata[AXES-1:0] : {AXES{1'b0}}) // R07
          & ~(errDis_reg & errTrip); // R16
      // one cycle behind the latch, straight from a flip-flop
      amplifierEnableOut <= ampOn_reg; // R08
      // commanded position lands with a position write for the errSel_reg axis, held later
      if (apbWr && paddr == `CRAMP_OFF_POS)
        cmdPos_reg[errSel_reg*POSW +: POSW] <= pwdata[POSW-1:0];
      dacOut <= dacNext;
      route_reg <= routeNext;
      irq <= |(irqSt_reg & irqMsk_reg);
    end
  end
  // encoder decode: quadrature x4 or pulse/direction
  reg [AXES*POSW-1:0] posNext;
  reg [AXES*2-1:0] dirNext;
  reg [1:0] st;
  reg fwd;
  integer q;
  always @*
  begin
    posNext = pos_reg;
    dirNext = lastDir_reg;
    st = 2'h0;
    fwd = 1'b0;
    for (q = 0; q < AXES; q = q + 1)
    begin
      st = {quadraturePhaseA[q] ^ qaOld_reg[q], quadraturePhaseB[q] ^ qbOld_reg[q]};
      // new a against old b is one on every forward step, either channel
      fwd = quadraturePhaseA[q] ^ qbOld_reg[q];
      if (encMode_reg[q])
      begin
        if (quadraturePhaseA[q] & ~qaOld_reg[q]) // R10
          posNext[q*POSW +: POSW] = quadraturePhaseB[q] ? pos_reg[q*POSW +: POSW] - 1'b1
            : pos_reg[q*POSW +: POSW] + 1'b1;
      end
      // both channels moving at once is a lost step, not counted
      else if (st == 2'h1 || st == 2'h2)
      begin
        // index ignored by the count path
        if (fwd) // R09
        begin
          // a lone channel bouncing reverses the prior step
          if (lastDir_reg[q*2 +: 2] != {st[1], 1'b1}) // R11
            posNext[q*POSW +: POSW] = pos_reg[q*POSW +: POSW] + 1'b1;
        end
        else if (lastDir_reg[q*2 +: 2] != {st[1], 1'b0}) // R11
          posNext[q*POSW +: POSW] = pos_reg[q*POSW +: POSW] - 1'b1;
        dirNext[q*2 +: 2] = {st[1], fwd};
      end
    end
  end
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_reg <= {AXES*POSW{1'b0}};
      qaOld_reg <= {AXES{1'b0}};
      qbOld_reg <= {AXES{1'b0}};
      lastDir_reg <= {AXES{2'h0}};
    end
    else
    begin
      pos_reg <= posNext;
      qaOld_reg <= quadraturePhaseA;
      qbOld_reg <= quadraturePhaseB;
      lastDir_reg <= dirNext;
    end
  end
  // gather each axis's three consecutive inputs from its chosen start
  always @*
  begin
    hallNow = {AXES{3'h0}};
    for (b = 0; b < AXES; b = b + 1)
      hallNow[b*3 +: 3] = { // R14 R15
        inBit(hallSel_reg[b*9 +: 7] + 7'd2, genIn, extIn, auxIn),
        inBit(hallSel_reg[b*9 +: 7] + 7'd1, genIn, extIn, auxIn),
        inBit(hallSel_reg[b*9 +: 7], genIn, extIn, auxIn)};
  end
  // hall capture from three consecutive inputs, seed phase once after reset
  integer h;
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hall_reg <= {AXES{3'h0}};
      phaseSeed_reg <= {AXES{3'h0}};
      seeded_reg <= {AXES{1'b0}};
    end
    else
      for (h = 0; h < AXES; h = h + 1)
        if (hallSel_reg[h*9 + 8]) // R13
        begin
          hall_reg[h*3 +: 3] <= hallNow[h*3 +: 3]; // R14 R15
          // seed from the live levels, not last cycle's capture
          if (!seeded_reg[h] && sinSel_reg[h])
          begin
            phaseSeed_reg[h*3 +: 3] <= hallNow[h*3 +: 3]; // R12
            seeded_reg[h] <= 1'b1;
          end
        end
        else if (apbWr && paddr == `CRAMP_OFF_PHASE && errSel_reg == h)
        begin
          phaseSeed_reg[h*3 +: 3] <= pwdata[2:0]; // R12
          seeded_reg[h] <= 1'b1;
        end
  end
endmodule
